// File: lcas_regs.svh
// Purpose: register map, field positions and reset values of the alarm status block
// Assumes: AXI4-Lite byte address is four times the register index
// Notes: channel register index is channel * 16 plus the low nibble below
`ifndef LCAS_REGS_SVH
`define LCAS_REGS_SVH
`define LCAS_NCH 4'hE
`define LCAS_IDX_EN 4'h4
`define LCAS_IDX_STATE 4'h5
`define LCAS_IDX_CHG 4'h6
`define LCAS_IDX_GCTL 10'h0E0
`define LCAS_IDX_GMODE 10'h0E5
`define LCAS_IDX_ISTAT 10'h0F0
`define LCAS_IDX_IMASK 10'h0F1
`define LCAS_GIE_BIT 0
`define LCAS_OVF_MODE_BIT 7
`define LCAS_B_LCV 4
`define LCAS_B_OVF 8
`define LCAS_RST_BYTE 8'h00
`define LCAS_RST_MASK 14'h3FFF
`define LCAS_RESP_OKAY 2'h0
`define LCAS_RESP_SLVERR 2'h2
`define LCAS_AW 12
`endif

// File: lcas_pkg.sv
// Purpose: state types of the alarm status block
// Assumes: widths follow lcas_regs.svh
// Notes: one packed struct per module holds all of its state
package lcas_pkg;
  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
    logic [7:0] live;
    logic [7:0] chg;
  } lcas_chan_st_t;

  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic aw_got;
    logic w_got;
    logic bvalid;
    logic [1:0] bresp;
    logic [9:0] widx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [13:0][7:0] en;
    logic global_irq_enable;
    logic ovf_mode;
    logic [13:0] istat;
    logic [13:0] imask;
    logic irq;
  } lcas_top_st_t;
endpackage

// File: lcas_chan_if.sv
// Purpose: signals between the register core and one channel's alarm logic
// Assumes: all signals on aclk
// Notes: raw carries unsynchronised pins, bit 8 is the counter overflow
`timescale 1ns/1ps
interface lcas_chan_if;
  logic [8:0] raw;
  logic ovf_mode;
  logic rd_clr;
  logic [7:0] live;
  logic [7:0] chg;
  modport chan(input raw, input ovf_mode, input rd_clr, output live, output chg);
  modport core(output raw, output ovf_mode, output rd_clr, input live, input chg);
endinterface

// File: lcas_chan.sv
// Purpose: synchronise one channel's alarm pins, hold live state and change latches
// Assumes: rd_clr pulses in the cycle the change register is read
// Notes: a change in the clearing cycle is kept, set wins over clear
`timescale 1ns/1ps
`include "lcas_regs.svh"
module lcas_chan (
  input logic aclk,
  input logic aresetn,
  lcas_chan_if.chan bus
);
  lcas_pkg::lcas_chan_st_t st_reg;
  lcas_pkg::lcas_chan_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = bus.raw;
    st_next.s2 = st_reg.s1;
    st_next.live = st_reg.s2[7:0];
    if (st_reg.s2[`LCAS_B_LCV] != 1'b0 && bus.ovf_mode) begin
      st_next.live[`LCAS_B_LCV] = st_reg.s2[`LCAS_B_OVF];
    end else if (bus.ovf_mode) begin
      st_next.live[`LCAS_B_LCV] = st_reg.s2[`LCAS_B_OVF];
    end
    st_next.chg = (st_reg.chg & ~{8{bus.rd_clr}}) | (st_next.live ^ st_reg.live);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.live = st_reg.live;
  assign bus.chg = st_reg.chg;

  property p_mux;
    @(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> bus.live[4] == ($past(bus.ovf_mode) ? $past(st_reg.s2[8])
      : $past(st_reg.s2[4]));
  endproperty
  live_mux_a: assert property (p_mux)
    else $error("D4 source does not follow the overflow mode");

  pin_latency_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ($past(aresetn) && $past(aresetn, 2) && $past(aresetn, 3))
      |-> (bus.live & 8'hEF) == ($past(bus.raw[7:0], 3) & 8'hEF))
    else $error("live alarm bit does not follow its pin after three cycles");

  chg_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> ((bus.live ^ $past(bus.live)) & ~bus.chg) == 8'h00)
    else $error("live change not latched");

  rd_clear_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    bus.rd_clr |=> bus.chg == (bus.live ^ $past(bus.live)))
    else $error("change register not cleared by read");
endmodule

// File: lcas_top.sv
// Purpose: per-channel alarm state, change latches and interrupt, AXI4-Lite slave
// Assumes: alarm pins are asynchronous; byte address is four times the register index
// Notes: change reads clear; interrupt summary is sticky, write one to clear
// Functional notes
// - Interrupt pin only when source enable and global irq enable are both one.
// - State bit D7 always shows the equalizer attenuation flag.
// - State bit D6 shows driver failure regardless of masking.
// - State bit D5 is one while FIFO pointers are within three.
// - D4 shows line code errors, or counter overflow when mode bit set.
// - In violation mode D4 is one on violation or excess zeros.
// - State bit D3 is one when a loop code is detected.
// - State bit D2 is one while all-ones signal is detected.
// - State bit D1 is one while receive signal is lost.
// - State bit D0 is one when a test pattern is detected.
// - Each change bit sets whenever its live state changes.
// - Reading the change register clears it.
// - Latched change interrupts when its enable, its channel's imask bit and global enable are one.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "lcas_regs.svh"
module lcas_top (
  input logic aclk,
  input logic aresetn,
  input logic [`LCAS_AW-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [`LCAS_AW-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [`LCAS_NCH-1:0] equalizer_loss_alarm,
  input logic [`LCAS_NCH-1:0] driver_failure_alarm,
  input logic [`LCAS_NCH-1:0] fifo_near_limit_alarm,
  input logic [`LCAS_NCH-1:0] line_code_error,
  input logic [`LCAS_NCH-1:0] counter_overflow,
  input logic [`LCAS_NCH-1:0] loop_code_found,
  input logic [`LCAS_NCH-1:0] all_ones_alarm,
  input logic [`LCAS_NCH-1:0] receive_signal_loss,
  input logic [`LCAS_NCH-1:0] test_pattern_match,
  output logic irq
);
  lcas_pkg::lcas_top_st_t st_reg;
  lcas_pkg::lcas_top_st_t st_next;

  logic [`LCAS_NCH-1:0][7:0] live_a;
  logic [`LCAS_NCH-1:0][7:0] chg_a;
  logic [`LCAS_NCH-1:0] pend;
  logic [`LCAS_NCH-1:0] rd_clr;
  logic hs_aw;
  logic hs_w;
  logic hs_ar;
  logic [9:0] ridx;
  logic [3:0] rch;
  logic rch_ok;
  logic rd_hit;
  logic rd_is_chg;
  logic [31:0] rd_data;
  logic [3:0] wch;
  logic wch_ok;
  logic wr_hit;

  // Each channel owns a private copy of its enable, state and change registers
  for (genvar i = 0; i < `LCAS_NCH; i++) begin : g_ch
    lcas_chan_if cif();
    assign cif.raw = {counter_overflow[i], equalizer_loss_alarm[i], driver_failure_alarm[i],
      fifo_near_limit_alarm[i], line_code_error[i], loop_code_found[i], all_ones_alarm[i],
      receive_signal_loss[i], test_pattern_match[i]};
    assign cif.ovf_mode = st_reg.ovf_mode;
    assign cif.rd_clr = rd_clr[i];
    assign live_a[i] = cif.live;
    assign chg_a[i] = cif.chg;
    assign pend[i] = |(cif.chg & st_reg.en[i]);
    lcas_chan u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .bus(cif.chan)
    );
  end

  assign hs_aw = s_axi_awvalid & st_reg.awrdy;
  assign hs_w = s_axi_wvalid & st_reg.wrdy;
  assign hs_ar = s_axi_arvalid & st_reg.arrdy;

  // Read decode: channel registers sit at channel * 16 plus a low index
  always_comb begin
    ridx = s_axi_araddr[`LCAS_AW-1:2];
    rch = ridx[7:4];
    rch_ok = (ridx[9:8] == 2'h0) && (rch < `LCAS_NCH);
    rd_hit = 1'b0;
    rd_is_chg = 1'b0;
    rd_data = 32'h0000_0000;
    if (rch_ok) begin
      unique case (ridx[3:0])
        `LCAS_IDX_EN: begin
          rd_hit = 1'b1;
          rd_data[7:0] = st_reg.en[rch];
        end
        `LCAS_IDX_STATE: begin
          rd_hit = 1'b1;
          rd_data[7:0] = live_a[rch];
        end
        `LCAS_IDX_CHG: begin
          rd_hit = 1'b1;
          rd_is_chg = 1'b1;
          rd_data[7:0] = chg_a[rch];
        end
        default: begin
          rd_hit = 1'b0;
        end
      endcase
    end
    if (ridx == `LCAS_IDX_GCTL) begin
      rd_hit = 1'b1;
      rd_data[`LCAS_GIE_BIT] = st_reg.global_irq_enable;
    end
    if (ridx == `LCAS_IDX_GMODE) begin
      rd_hit = 1'b1;
      rd_data[`LCAS_OVF_MODE_BIT] = st_reg.ovf_mode;
    end
    if (ridx == `LCAS_IDX_ISTAT) begin
      rd_hit = 1'b1;
      rd_data[13:0] = st_reg.istat;
    end
    if (ridx == `LCAS_IDX_IMASK) begin
      rd_hit = 1'b1;
      rd_data[13:0] = st_reg.imask;
    end
  end

  // Clear pulse reaches the channel in the same cycle its change bits are sampled
  always_comb begin
    rd_clr = '0;
    if (hs_ar && rd_is_chg) begin
      rd_clr[rch] = 1'b1;
    end
  end

  assign wch = st_reg.widx[7:4];
  assign wch_ok = (st_reg.widx[9:8] == 2'h0) && (wch < `LCAS_NCH);
  assign wr_hit = (wch_ok && (st_reg.widx[3:0] == `LCAS_IDX_EN ||
    st_reg.widx[3:0] == `LCAS_IDX_STATE || st_reg.widx[3:0] == `LCAS_IDX_CHG)) ||
    st_reg.widx == `LCAS_IDX_GCTL || st_reg.widx == `LCAS_IDX_GMODE ||
    st_reg.widx == `LCAS_IDX_ISTAT || st_reg.widx == `LCAS_IDX_IMASK;

  always_comb begin
    st_next = st_reg;
    if (hs_aw) begin
      st_next.aw_got = 1'b1;
      st_next.widx = s_axi_awaddr[`LCAS_AW-1:2];
    end
    if (hs_w) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // Sticky summary; a new pending change outranks a software clear
    st_next.istat = st_reg.istat;
    // Writes take effect once address and data are both held
    if (st_reg.aw_got && st_reg.w_got) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = wr_hit ? `LCAS_RESP_OKAY : `LCAS_RESP_SLVERR;
      if (wch_ok && st_reg.widx[3:0] == `LCAS_IDX_EN && st_reg.wstrb[0]) begin
        st_next.en[wch] = st_reg.wdata[7:0];
      end
      if (st_reg.widx == `LCAS_IDX_GCTL && st_reg.wstrb[0]) begin
        st_next.global_irq_enable = st_reg.wdata[`LCAS_GIE_BIT];
      end
      if (st_reg.widx == `LCAS_IDX_GMODE && st_reg.wstrb[0]) begin
        st_next.ovf_mode = st_reg.wdata[`LCAS_OVF_MODE_BIT];
      end
      if (st_reg.widx == `LCAS_IDX_ISTAT) begin
        if (st_reg.wstrb[0]) begin
          st_next.istat[7:0] = st_reg.istat[7:0] & ~st_reg.wdata[7:0];
        end
        if (st_reg.wstrb[1]) begin
          st_next.istat[13:8] = st_reg.istat[13:8] & ~st_reg.wdata[13:8];
        end
      end
      if (st_reg.widx == `LCAS_IDX_IMASK) begin
        if (st_reg.wstrb[0]) begin
          st_next.imask[7:0] = st_reg.wdata[7:0];
        end
        if (st_reg.wstrb[1]) begin
          st_next.imask[13:8] = st_reg.wdata[13:8];
        end
      end
    end
    st_next.istat = st_next.istat | pend;
    st_next.awrdy = ~st_next.aw_got & ~st_next.bvalid;
    st_next.wrdy = ~st_next.w_got & ~st_next.bvalid;
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (hs_ar) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_data;
      st_next.rresp = rd_hit ? `LCAS_RESP_OKAY : `LCAS_RESP_SLVERR;
    end
    st_next.arrdy = ~st_next.rvalid;
    // Global enable gates the pin, not the latching, so nothing is lost while off;
    // the pin follows the latched changes, the sticky summary only locates them
    st_next.irq = st_reg.global_irq_enable & |(pend & st_reg.imask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.imask <= `LCAS_RST_MASK;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awrdy;
  assign s_axi_wready = st_reg.wrdy;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arrdy;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign irq = st_reg.irq;

  sequence s_pend_seen;
    st_reg.global_irq_enable && |(pend & st_reg.imask);
  endsequence

  sequence s_write_commit;
    st_reg.aw_got && st_reg.w_got;
  endsequence

  sequence s_read_state;
    hs_ar && rch_ok && ridx[3:0] == `LCAS_IDX_STATE;
  endsequence

  sequence s_read_chg;
    hs_ar && rd_is_chg;
  endsequence

  property p_gie_gate;
    @(posedge aclk) disable iff (!aresetn)
    !st_reg.global_irq_enable |=> !irq;
  endproperty
  gie_gate_a: assert property (p_gie_gate)
    else $error("interrupt raised with global enable off");

  property p_irq_cause;
    @(posedge aclk) disable iff (!aresetn)
    s_pend_seen |=> irq;
  endproperty
  irq_cause_a: assert property (p_irq_cause)
    else $error("enabled change did not raise the interrupt");

  irq_source_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(irq) |-> $past(st_reg.global_irq_enable) && $past(|(pend & st_reg.imask)))
    else $error("interrupt without enabled source");

  property p_read_state;
    @(posedge aclk) disable iff (!aresetn)
    s_read_state |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(live_a[rch]);
  endproperty
  read_state_a: assert property (p_read_state)
    else $error("state read returned wrong channel data");

  property p_read_chg;
    @(posedge aclk) disable iff (!aresetn)
    s_read_chg |-> rd_clr != '0 ##1 s_axi_rvalid && s_axi_rresp == `LCAS_RESP_OKAY;
  endproperty
  read_chg_a: assert property (p_read_chg)
    else $error("change read did not clear or answer");

  unmapped_read_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    hs_ar && !rd_hit |=> s_axi_rresp == `LCAS_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  write_order_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_bvalid) |-> $past(st_reg.aw_got) && $past(st_reg.w_got))
    else $error("write response before address and data");

  resp_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before taken");

  irq_drop_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (pend & st_reg.imask) == '0 |=> !irq)
    else $error("interrupt held with no enabled change");

  summary_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    pend != '0 |=> (st_reg.istat & $past(pend)) == $past(pend))
    else $error("pending change lost from the summary");

  property p_enable_write;
    @(posedge aclk) disable iff (!aresetn)
    s_write_commit ##0 (wch_ok && st_reg.widx[3:0] == `LCAS_IDX_EN && st_reg.wstrb[0])
      |=> st_reg.en[$past(wch)] == $past(st_reg.wdata[7:0]);
  endproperty
  enable_write_a: assert property (p_enable_write)
    else $error("enable write did not reach its channel");

  gmode_write_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_write_commit ##0 (st_reg.widx == `LCAS_IDX_GMODE && st_reg.wstrb[0])
      |=> st_reg.ovf_mode == $past(st_reg.wdata[`LCAS_OVF_MODE_BIT]))
    else $error("overflow mode write lost");

  chg_data_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_read_chg |=> s_axi_rdata[7:0] == $past(chg_a[rch]))
    else $error("change read lost the pre-clear value");

  bresp_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped before taken");

  write_block_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel open while an answer waits");

  read_block_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while an answer waits");
endmodule

// File: lcas_host_model.sv
// Purpose: AXI4-Lite host model that reaches the alarm block registers
// Assumes: one write and one read at a time, all changes just after a rising edge
// Notes: waits without limit, the bench timeout ends a hang
`timescale 1ns/1ps
module lcas_host_model (
  input logic aclk,
  output logic [11:0] awaddr,
  output logic awvalid,
  input logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input logic wready,
  input logic [1:0] bresp,
  input logic bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input logic arready,
  input logic [31:0] rdata,
  input logic [1:0] rresp,
  input logic rvalid,
  output logic rready
);
  initial begin
    awaddr = 12'h000;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 12'h000;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Each channel is released at its own handshake edge
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// File: tb.sv
// Purpose: self-checking bench of the alarm status and interrupt block
// Assumes: pin to state bit takes 3 edges, pin to irq 4 edges
// Notes: alarm row 8 is the counter overflow pin, rows 7..0 follow D7..D0
`timescale 1ns/1ps
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [8:0][13:0] alm = '0;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;

  always #25 aclk = ~aclk;

  lcas_top i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .equalizer_loss_alarm(alm[7]), .driver_failure_alarm(alm[6]),
    .fifo_near_limit_alarm(alm[5]), .line_code_error(alm[4]), .counter_overflow(alm[8]),
    .loop_code_found(alm[3]), .all_ones_alarm(alm[2]), .receive_signal_loss(alm[1]),
    .test_pattern_match(alm[0]), .irq(irq));

  lcas_host_model i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  function automatic logic [11:0] ad(input int c, input int k);
    return 12'((c * 16 + k) * 4);
  endfunction

  task give_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    i_host.rd(a, d, r);
    chk(what, d, exp);
  endtask

  task wrc(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp);
    logic [1:0] r;
    i_host.wr(a, d, r);
    chk("bresp", 32'(r), 32'(exp));
  endtask

  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    tick(2);
    aresetn <= 1'b1;
    tick(1);
    rdc("state rst", ad(3, 5), 32'h00000000);
    rdc("change rst", ad(3, 6), 32'h00000000);
    rdc("enable rst", ad(3, 4), 32'h00000000);
    rdc("mask rst", 12'h3C4, 32'h00003FFF);
    i_host.rd(12'h01C, d, r);
    chk("unmapped resp", 32'(r), 32'h00000002);
    chk("unmapped data", d, 32'h00000000);
    wrc(12'h01C, 32'h00000000, 2'h2);
    chk("irq rst", 32'(irq), 32'h00000000);
    $display("test reset done");
    // Each source of D7..D0 high then low on channel 3; channel 0 must stay quiet
    for (int b = 0; b < 8; b++) begin
      alm[b][3] <= 1'b1;
      tick(5);
      rdc("state", ad(3, 5), 32'h1 << b);
      rdc("state", ad(3, 5), 32'h1 << b);
      rdc("other chan", ad(0, 5), 32'h00000000);
      wrc(ad(3, 5), 32'h00000000, 2'h0);
      rdc("state ro", ad(3, 5), 32'h1 << b);
      rdc("change rise", ad(3, 6), 32'h1 << b);
      rdc("change clr", ad(3, 6), 32'h00000000);
      alm[b][3] <= 1'b0;
      tick(5);
      rdc("change fall", ad(3, 6), 32'h1 << b);
      rdc("state low", ad(3, 5), 32'h00000000);
    end
    $display("test live done");
    wrc(12'h394, 32'h00000080, 2'h0);
    rdc("mode read", 12'h394, 32'h00000080);
    alm[4][3] <= 1'b1;
    tick(5);
    rdc("ovf mode lcv", ad(3, 5), 32'h00000000);
    alm[8][3] <= 1'b1;
    tick(5);
    rdc("ovf mode ovf", ad(3, 5), 32'h00000010);
    wrc(12'h394, 32'h00000000, 2'h0);
    alm[8][3] <= 1'b0;
    tick(5);
    rdc("lcv mode", ad(3, 5), 32'h00000010);
    alm[4][3] <= 1'b0;
    tick(5);
    rdc("mode change", ad(3, 6), 32'h00000010);
    $display("test mode done");
    wrc(ad(3, 4), 32'h00000002, 2'h0);
    rdc("enable", ad(3, 4), 32'h00000002);
    alm[1][3] <= 1'b1;
    tick(8);
    chk("irq gie off", 32'(irq), 32'h00000000);
    wrc(12'h380, 32'h00000001, 2'h0);
    tick(3);
    chk("irq on", 32'(irq), 32'h00000001);
    rdc("gie read", 12'h380, 32'h00000001);
    rdc("summary", 12'h3C0, 32'h00000008);
    rdc("change", ad(3, 6), 32'h00000002);
    tick(2);
    chk("irq chg read", 32'(irq), 32'h00000000);
    wrc(12'h3C0, 32'h00000008, 2'h0);
    tick(3);
    chk("irq cleared", 32'(irq), 32'h00000000);
    rdc("summary clr", 12'h3C0, 32'h00000000);
    alm[0][3] <= 1'b1;
    tick(8);
    chk("irq masked src", 32'(irq), 32'h00000000);
    wrc(ad(5, 4), 32'h00000001, 2'h0);
    alm[0][5] <= 1'b1;
    tick(8);
    chk("irq chan 5", 32'(irq), 32'h00000001);
    rdc("summary ch5", 12'h3C0, 32'h00000020);
    wrc(12'h3C4, 32'h00000000, 2'h0);
    tick(3);
    chk("irq mask off", 32'(irq), 32'h00000000);
    wrc(12'h3C4, 32'h00003FFF, 2'h0);
    tick(3);
    chk("irq mask on", 32'(irq), 32'h00000001);
    $display("test irq done");
    give_verdict();
  end
endmodule
